// ===== core/usr8_pkg.sv
// Constants, mode type and mode decode for the eight-bit universal shift register.
// Assumes a single 100 MHz system clock; all pins are sampled on it.
package usr8_pkg;

    // Register geometry
    localparam int unsigned REG_WIDTH  = 8;
    localparam int unsigned FIRST_BIT  = 0;
    localparam int unsigned LAST_BIT   = REG_WIDTH - 1;
    localparam logic [7:0]  REG_RESET  = 8'h00;

    // Snapshot buffer geometry
    localparam int unsigned SNAP_WIDTH = REG_WIDTH;
    localparam int unsigned SNAP_DEPTH = 4;

    // Clock rate, for reference of timing figures
    localparam int unsigned CLK_PERIOD_NS = 10;

    typedef enum logic [1:0]
    {
        MODE_HOLD,
        MODE_SHIFT_RIGHT,
        MODE_SHIFT_LEFT,
        MODE_LOAD
    } mode_t;

    // Two select inputs to one of four modes
    function automatic mode_t mode_decode(input logic sel_high, input logic sel_low);
        mode_t m;
        m = MODE_HOLD;
        case ({sel_high, sel_low})
            2'b00: m = MODE_HOLD;
            2'b01: m = MODE_SHIFT_RIGHT;
            2'b10: m = MODE_SHIFT_LEFT;
            default: m = MODE_LOAD;
        endcase
        return m;
    endfunction

endpackage

// ===== core/snap_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module snap_fifo
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
)
(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] rd_ptr_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             push;
    logic             pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        logic [PTR_W-1:0] r;
        r = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
        return r;
    endfunction

    assign in_ready_o  = (count_q != CNT_W'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        wr_ptr_d = push ? ptr_inc(wr_ptr_q) : wr_ptr_q;
        rd_ptr_d = pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;
        count_d  = count_q;
        if (push && !pop)
        begin
            count_d = CNT_W'(count_q + 1'b1);
        end
        else if (pop && !push)
        begin
            count_d = CNT_W'(count_q - 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // Storage needs no reset; valid gates every read
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

endmodule // snap_fifo

// ===== core/univ_shift_reg.sv
// Eight-bit universal shift register: hold, shift right, shift left, parallel load.
// Assumes all pins synchronous to clk_i; the shift clock is a sampled input whose
// rising edge is the active transition. The far end resolves the shared port
// from parallel_io_o and parallel_io_oe_o.
`timescale 1ns/10ps
module univ_shift_reg
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       mode_select_low_i,
    input  wire logic       mode_select_high_i,
    input  wire logic       port_disable_a_i,
    input  wire logic       port_disable_b_i,
    input  wire logic       register_reset_n_i,
    input  wire logic       shift_clock_i,
    input  wire logic       left_serial_in_i,
    input  wire logic       right_serial_in_i,
    input  wire logic [7:0] parallel_io_i,
    output logic      [7:0] parallel_io_o,
    output logic            parallel_io_oe_o,
    output logic            first_stage_serial_out_o,
    output logic            last_stage_serial_out_o,
    output logic      [7:0] snap_data_o,
    output logic            snap_valid_o,
    input  wire logic       snap_ready_i,
    output logic            snap_room_o,
    output logic            snap_lost_o
);

    // Mode and clock edge
    usr8_pkg::mode_t  mode;
    logic             clear_active;
    logic             sclk_q;
    logic             sclk_d;
    logic             sclk_rise;
    logic             step;

    // Register
    logic [7:0]       shreg_q;
    logic [7:0]       shreg_d;
    logic [7:0]       step_word;

    // Snapshot stream
    logic             snap_push_q;
    logic             snap_push_d;
    logic [7:0]       snap_word_q;
    logic [7:0]       snap_word_d;
    logic             snap_lost_q;
    logic             snap_lost_d;
    logic             fifo_in_ready;

    // Toward the last stage: every stage takes its lower neighbour, the first takes the fill
    function automatic logic [7:0] shift_toward_last
    (
        input logic [7:0] cur,
        input logic       fill
    );
        logic [7:0] nxt;
        nxt = {cur[usr8_pkg::LAST_BIT-1:usr8_pkg::FIRST_BIT], fill};
        return nxt;
    endfunction

    // Toward the first stage: every stage takes its upper neighbour, the last takes the fill
    function automatic logic [7:0] shift_toward_first
    (
        input logic [7:0] cur,
        input logic       fill
    );
        logic [7:0] nxt;
        nxt = {fill, cur[usr8_pkg::LAST_BIT:usr8_pkg::FIRST_BIT+1]};
        return nxt;
    endfunction

    // One shift or load step from the present contents
    function automatic logic [7:0] step_value
    (
        input usr8_pkg::mode_t m,
        input logic [7:0]      cur,
        input logic            sl_in,
        input logic            sr_in,
        input logic [7:0]      par_in
    );
        logic [7:0] nxt;
        nxt = cur;
        case (m)
            usr8_pkg::MODE_SHIFT_RIGHT:
            begin
                nxt = shift_toward_last(cur, sr_in);
            end
            usr8_pkg::MODE_SHIFT_LEFT:
            begin
                nxt = shift_toward_first(cur, sl_in);
            end
            usr8_pkg::MODE_LOAD:
            begin
                nxt = par_in;
            end
            default:
            begin
                nxt = cur;
            end
        endcase
        return nxt;
    endfunction

    // Select pins to mode; clear is a level above every mode
    always_comb
    begin
        mode         = usr8_pkg::mode_decode(mode_select_high_i, mode_select_low_i);
        clear_active = !register_reset_n_i;
    end

    // Shift clock edge detect; a clock already high at reset release
    // counts as a rise, so keep it low until the first request
    always_comb
    begin
        sclk_d = shift_clock_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sclk_q <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk_d;
        end
    end

    assign sclk_rise = shift_clock_i && !sclk_q;

    // A step needs a fresh rise, clear released and a mode other than hold
    always_comb
    begin
        step = 1'b0;
        if (sclk_rise)
        begin
            if (clear_active)
            begin
                step = 1'b0;
            end
            else if (mode == usr8_pkg::MODE_HOLD)
            begin
                step = 1'b0;
            end
            else
            begin
                step = 1'b1;
            end
        end
    end

    // Value after a step, shared by the register and its snapshot
    always_comb
    begin
        step_word = step_value(mode, shreg_q, left_serial_in_i, right_serial_in_i, parallel_io_i);
    end

    // Register contents; disable inputs take no part here
    // Clear empties the register at the next edge; the pins read zero at once
    always_comb
    begin
        shreg_d = shreg_q;
        if (clear_active)
        begin
            shreg_d = usr8_pkg::REG_RESET;
        end
        else if (step)
        begin
            shreg_d = step_word;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            shreg_q <= usr8_pkg::REG_RESET;
        end
        else
        begin
            shreg_q <= shreg_d;
        end
    end

    // Clear shows at the pins in the same cycle, before the edge empties the register
    // The serial outputs never float, whatever the disables and select
    always_comb
    begin
        parallel_io_o            = shreg_q;
        first_stage_serial_out_o = shreg_q[usr8_pkg::FIRST_BIT];
        last_stage_serial_out_o  = shreg_q[usr8_pkg::LAST_BIT];
        if (clear_active)
        begin
            parallel_io_o            = usr8_pkg::REG_RESET;
            first_stage_serial_out_o = 1'b0;
            last_stage_serial_out_o  = 1'b0;
        end
    end

    // Port drives except in load or while floated; the far end waits for this
    // Both disables act alike; either one floats all eight terminals
    always_comb
    begin
        parallel_io_oe_o = 1'b1;
        if (port_disable_a_i || port_disable_b_i)
        begin
            parallel_io_oe_o = 1'b0;
        end
        else if (mode == usr8_pkg::MODE_LOAD)
        begin
            parallel_io_oe_o = 1'b0;
        end
        else
        begin
            parallel_io_oe_o = 1'b1;
        end
    end

    // Snapshot of each new value, pushed one cycle after the step
    // Clear and hold never push, since step stays low then
    always_comb
    begin
        snap_push_d = step;
        snap_word_d = snap_word_q;
        if (step)
        begin
            snap_word_d = step_word;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            snap_push_q <= 1'b0;
            snap_word_q <= usr8_pkg::REG_RESET;
        end
        else
        begin
            snap_push_q <= snap_push_d;
            snap_word_q <= snap_word_d;
        end
    end

    // Sticky loss flag; only reset clears it. A step cannot be refused,
    // so a full buffer drops the word rather than stalling the register
    always_comb
    begin
        snap_lost_d = snap_lost_q;
        if (snap_push_q && !fifo_in_ready)
        begin
            snap_lost_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            snap_lost_q <= 1'b0;
        end
        else
        begin
            snap_lost_q <= snap_lost_d;
        end
    end

    assign snap_lost_o = snap_lost_q;
    assign snap_room_o = fifo_in_ready;

    // Holds up to four snapshots until the consumer takes them
    snap_fifo
    #(
        .WIDTH (usr8_pkg::SNAP_WIDTH),
        .DEPTH (usr8_pkg::SNAP_DEPTH)
    )
    u_snap_fifo
    (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .in_data_i   (snap_word_q),
        .in_valid_i  (snap_push_q),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (snap_data_o),
        .out_valid_o (snap_valid_o),
        .out_ready_i (snap_ready_i)
    );

endmodule // univ_shift_reg

// ===== verif/far_port.sv
// Far-side logic sharing the parallel port, plus the resolved port level.
// Assumes the device drive value and enable come straight from the block.
`timescale 1ns/10ps
module far_port
#(
    parameter logic [7:0] PULL_LEVEL = 8'hFF
)
(
    input  wire logic       dev_oe_i,
    input  wire logic [7:0] dev_val_i,
    input  wire logic       far_en_i,
    input  wire logic [7:0] far_val_i,
    output logic      [7:0] bus_o
);
    // Far side yields while the device drives; an idle port sits at the pull level
    always_comb
    begin
        if (dev_oe_i)
            bus_o = dev_val_i;
        else if (far_en_i)
            bus_o = far_val_i;
        else
            bus_o = PULL_LEVEL;
    end
endmodule // far_port

// ===== verif/univ_shift_reg_chk.sv
// Port checker for the shift register, bound to its top module.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module univ_shift_reg_chk
(
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       mode_select_low_i,
    input wire logic       mode_select_high_i,
    input wire logic       port_disable_a_i,
    input wire logic       port_disable_b_i,
    input wire logic       register_reset_n_i,
    input wire logic       shift_clock_i,
    input wire logic       left_serial_in_i,
    input wire logic       right_serial_in_i,
    input wire logic [7:0] parallel_io_i,
    input wire logic [7:0] parallel_io_o,
    input wire logic       parallel_io_oe_o,
    input wire logic       first_stage_serial_out_o,
    input wire logic       last_stage_serial_out_o
);
    logic sc_q;
    logic rise;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            sc_q <= 1'b0;
        else
            sc_q <= shift_clock_i;
    end
    assign rise = shift_clock_i && !sc_q && register_reset_n_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_float; port_disable_a_i || port_disable_b_i |-> !parallel_io_oe_o; endproperty
    a_float: assert property (p_float) else $error("port driven while disabled");
    property p_drive; !port_disable_a_i && !port_disable_b_i && !(mode_select_high_i && mode_select_low_i)
        |-> parallel_io_oe_o; endproperty
    a_drive: assert property (p_drive) else $error("port not driven");
    property p_clear; !register_reset_n_i |-> parallel_io_o == 8'h00 && !first_stage_serial_out_o
        && !last_stage_serial_out_o ##1 parallel_io_o == 8'h00; endproperty
    a_clear: assert property (p_clear) else $error("clear not honoured");
    property p_hold; register_reset_n_i && !mode_select_high_i && !mode_select_low_i
        |=> !register_reset_n_i || $stable(parallel_io_o); endproperty
    a_hold: assert property (p_hold) else $error("register moved in hold");
    property p_right; rise && !mode_select_high_i && mode_select_low_i |=> !register_reset_n_i
        || parallel_io_o == {$past(parallel_io_o[6:0]), $past(right_serial_in_i)}; endproperty
    a_right: assert property (p_right) else $error("bad right shift");
    property p_left; rise && mode_select_high_i && !mode_select_low_i |=> !register_reset_n_i
        || parallel_io_o == {$past(left_serial_in_i), $past(parallel_io_o[7:1])}; endproperty
    a_left: assert property (p_left) else $error("bad left shift");
    property p_load; rise && mode_select_high_i && mode_select_low_i |-> !parallel_io_oe_o
        ##1 (!register_reset_n_i || parallel_io_o == $past(parallel_io_i)); endproperty
    a_load: assert property (p_load) else $error("bad parallel load");
    property p_idle; register_reset_n_i && !rise |=> !register_reset_n_i || $stable(parallel_io_o); endproperty
    a_idle: assert property (p_idle) else $error("register moved without clock rise");
    property p_serial; first_stage_serial_out_o == parallel_io_o[0] && last_stage_serial_out_o == parallel_io_o[7];
    endproperty
    a_serial: assert property (p_serial) else $error("serial outputs wrong");
    c_load: cover property (rise && mode_select_high_i && mode_select_low_i && port_disable_a_i);
    c_shift: cover property (rise && !mode_select_high_i && mode_select_low_i);
    c_clear: cover property (!register_reset_n_i && shift_clock_i);
endmodule // univ_shift_reg_chk
bind univ_shift_reg univ_shift_reg_chk u_univ_shift_reg_chk
(
    .clk_i                    (clk_i),
    .rstn_i                   (rstn_i),
    .mode_select_low_i        (mode_select_low_i),
    .mode_select_high_i       (mode_select_high_i),
    .port_disable_a_i         (port_disable_a_i),
    .port_disable_b_i         (port_disable_b_i),
    .register_reset_n_i       (register_reset_n_i),
    .shift_clock_i            (shift_clock_i),
    .left_serial_in_i         (left_serial_in_i),
    .right_serial_in_i        (right_serial_in_i),
    .parallel_io_i            (parallel_io_i),
    .parallel_io_o            (parallel_io_o),
    .parallel_io_oe_o         (parallel_io_oe_o),
    .first_stage_serial_out_o (first_stage_serial_out_o),
    .last_stage_serial_out_o  (last_stage_serial_out_o)
);

// ===== verif/univ_shift_reg_test.sv
// Self-checking bench for the shift register and its snapshot stream.
// Assumes the far side is modelled by far_port on the parallel port.
`timescale 1ns/10ps
module univ_shift_reg_test;
    logic       clk_i, rstn_i, mode_select_low_i, mode_select_high_i, port_disable_a_i, port_disable_b_i;
    logic       register_reset_n_i, shift_clock_i, left_serial_in_i, right_serial_in_i, parallel_io_oe_o;
    logic       first_stage_serial_out_o, last_stage_serial_out_o, snap_valid_o, snap_ready_i, snap_room_o;
    logic       snap_lost_o, far_en;
    logic [7:0] parallel_io_i, parallel_io_o, snap_data_o, far_val, exp_q;
    logic [7:0] snaps[$];
    int         num_errors, compares;
    univ_shift_reg u_univ_shift_reg
    (
        .clk_i(clk_i), .rstn_i(rstn_i), .mode_select_low_i(mode_select_low_i),
        .mode_select_high_i(mode_select_high_i), .port_disable_a_i(port_disable_a_i),
        .port_disable_b_i(port_disable_b_i), .register_reset_n_i(register_reset_n_i),
        .shift_clock_i(shift_clock_i), .left_serial_in_i(left_serial_in_i),
        .right_serial_in_i(right_serial_in_i), .parallel_io_i(parallel_io_i), .parallel_io_o(parallel_io_o),
        .parallel_io_oe_o(parallel_io_oe_o), .first_stage_serial_out_o(first_stage_serial_out_o),
        .last_stage_serial_out_o(last_stage_serial_out_o), .snap_data_o(snap_data_o),
        .snap_valid_o(snap_valid_o), .snap_ready_i(snap_ready_i), .snap_room_o(snap_room_o),
        .snap_lost_o(snap_lost_o)
    );
    far_port u_far_port (.dev_oe_i(parallel_io_oe_o), .dev_val_i(parallel_io_o), .far_en_i(far_en),
        .far_val_i(far_val), .bus_o(parallel_io_i));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One shift clock pulse in mode m; far side drives p only in load
    task automatic step(input logic [1:0] m, input logic l, input logic r, input logic [7:0] p);
        @(negedge clk_i);
        {mode_select_high_i, mode_select_low_i} = m;
        left_serial_in_i = l;
        right_serial_in_i = r;
        far_val = p;
        far_en = (m == 2'b11);
        shift_clock_i = 1'b1;
        @(negedge clk_i);
        shift_clock_i = 1'b0;
        if (!register_reset_n_i)
            exp_q = 8'h00;
        else if (m == 2'b01)
            exp_q = {exp_q[6:0], r};
        else if (m == 2'b10)
            exp_q = {l, exp_q[7:1]};
        else if (m == 2'b11)
            exp_q = p;
        if (register_reset_n_i && m != 2'b00)
            snaps.push_back(exp_q);
        check("register", parallel_io_o, exp_q);
        check("serial", {6'h00, last_stage_serial_out_o, first_stage_serial_out_o}, {6'h00, exp_q[7], exp_q[0]});
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        {rstn_i, mode_select_low_i, mode_select_high_i, port_disable_a_i, port_disable_b_i} = 5'h00;
        {shift_clock_i, left_serial_in_i, right_serial_in_i, far_en, snap_ready_i} = 5'h00;
        register_reset_n_i = 1'b1;
        far_val = 8'h00;
        exp_q = 8'h00;
        num_errors = 0;
        compares = 0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        check("after reset", {snap_lost_o, snap_valid_o, snap_room_o, parallel_io_o[4:0]}, 8'h20);
        // Drive enable for every mode and disable combination
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk_i);
            {mode_select_high_i, mode_select_low_i, port_disable_a_i, port_disable_b_i} = i[3:0];
            #2 check("oe", {7'h00, parallel_io_oe_o}, {7'h00, i[1:0] == 2'b00 && i[3:2] != 2'b11});
        end
        @(negedge clk_i);
        {port_disable_b_i, port_disable_a_i} = 2'b01;
        step(2'b11, 1'b0, 1'b0, 8'hA5);
        step(2'b01, 1'b0, 1'b1, 8'h00);
        port_disable_a_i = 1'b0;
        step(2'b01, 1'b1, 1'b0, 8'h00);
        step(2'b10, 1'b1, 1'b0, 8'h00);
        step(2'b10, 1'b0, 1'b1, 8'h00);
        @(negedge clk_i);
        check("fifo full", {6'h00, snap_lost_o, snap_room_o}, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            check("snap valid", {7'h00, snap_valid_o}, 8'h01);
            check("snap data", snap_data_o, snaps[k]);
            snap_ready_i = 1'b1;
            @(negedge clk_i);
            snap_ready_i = 1'b0;
        end
        check("fifo empty", {6'h00, snap_valid_o, snap_room_o}, 8'h01);
        snap_ready_i = 1'b1;
        step(2'b00, 1'b1, 1'b1, 8'h00);
        @(negedge clk_i);
        register_reset_n_i = 1'b0;
        #1 check("clear now", {parallel_io_o[5:0], last_stage_serial_out_o, first_stage_serial_out_o}, 8'h00);
        step(2'b01, 1'b1, 1'b1, 8'h00);
        register_reset_n_i = 1'b1;
        step(2'b01, 1'b1, 1'b1, 8'h00);
        tally_and_finish();
    end
endmodule // univ_shift_reg_test
